// [sfrp_cfg.svh]
// Timing and table constants for the flash reset and power-on sequencer
`ifndef SFRP_CFG_SVH
`define SFRP_CFG_SVH

`define SFRP_MCLK_NS        5
`define SFRP_CYC(ns)        (((ns) + `SFRP_MCLK_NS - 1) / `SFRP_MCLK_NS)

`define SFRP_T_LOW_NS       10000
`define SFRP_T_POR_NS       35000
`define SFRP_T_READ_NS      35000
`define SFRP_T_DECODE_NS    40000
`define SFRP_T_PROG_NS      310000
`define SFRP_T_SECTOR_NS    12000000
`define SFRP_T_BLOCK_NS     25000000
`define SFRP_T_CHIP_NS      100000000
`define SFRP_T_WRSTAT_NS    40000000

`define SFRP_LOW_W          12
`define SFRP_REC_W          25

`define SFRP_OFS_ERASE_4K   9'h01c
`define SFRP_OFS_ERASE_32K  9'h01e
`define SFRP_OFS_ERASE_64K  9'h020
`define SFRP_EXP_4K         8'h0c
`define SFRP_EXP_32K        8'h0f
`define SFRP_EXP_64K        8'h10
`define SFRP_BLANK          8'hff

`endif

// [sfrp_pkg.sv]
// Types for the flash reset and power-on sequencer
package sfrp_pkg;

  typedef enum logic [2:0] {
    SFRP_OP_IDLE   = 3'h0,
    SFRP_OP_DECODE = 3'h1,
    SFRP_OP_READ   = 3'h2,
    SFRP_OP_PROG   = 3'h3,
    SFRP_OP_SECTOR = 3'h4,
    SFRP_OP_BLOCK  = 3'h5,
    SFRP_OP_CHIP   = 3'h6,
    SFRP_OP_WRSTAT = 3'h7
  } sfrp_op_t;

  typedef enum logic [3:0] {
    SFRP_ST_POR     = 4'h1,
    SFRP_ST_RUN     = 4'h2,
    SFRP_ST_RST_LOW = 4'h4,
    SFRP_ST_RECOVER = 4'h8
  } sfrp_state_t;

  typedef struct packed {
    logic [2:0] op_lanes;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
  } sfrp_lanes_t;

  typedef struct packed {
    logic core_rst;
    logic so_hiz;
    logic cmd_ready;
    logic standby;
  } sfrp_status_t;

endpackage : sfrp_pkg

// [sfrp_seq.sv]
// Reset pin, power-on and parameter-table sequencing for a serial flash
`timescale 1ns/1ps
`include "sfrp_cfg.svh"

module sfrp_seq
  import sfrp_pkg::*;
#(
  parameter int unsigned P_POR_CYC    = `SFRP_CYC(`SFRP_T_POR_NS),
  parameter int unsigned P_READ_CYC   = `SFRP_CYC(`SFRP_T_READ_NS),
  parameter int unsigned P_DECODE_CYC = `SFRP_CYC(`SFRP_T_DECODE_NS),
  parameter int unsigned P_PROG_CYC   = `SFRP_CYC(`SFRP_T_PROG_NS),
  parameter int unsigned P_SECTOR_CYC = `SFRP_CYC(`SFRP_T_SECTOR_NS),
  parameter int unsigned P_BLOCK_CYC  = `SFRP_CYC(`SFRP_T_BLOCK_NS),
  parameter int unsigned P_CHIP_CYC   = `SFRP_CYC(`SFRP_T_CHIP_NS),
  parameter int unsigned P_WRSTAT_CYC = `SFRP_CYC(`SFRP_T_WRSTAT_NS)
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // Pins and supply monitor
  input  wire logic         i_reset_pin_n,
  input  wire logic         i_supply_low,
  // Flash core
  input  wire sfrp_op_t     i_op,
  output sfrp_status_t      o_status,
  output logic              o_abort,
  output logic              o_clear_volatile,
  output logic              o_write_enable_latch_clr,
  // Parameter table read
  input  wire sfrp_lanes_t  i_sfdp_lanes,
  output logic              o_sfdp_legal,
  input  wire logic [8:0]   i_param_addr,
  output logic [7:0]        o_param_byte,
  // Read framing
  input  wire logic [5:0]   i_addr_bits,
  input  wire logic [3:0]   i_mode_bits,
  input  wire logic [4:0]   i_wait_states,
  output logic [6:0]        o_data_lead
);

  localparam int unsigned              LW    = `SFRP_LOW_W;
  localparam int unsigned              RW    = `SFRP_REC_W;
  localparam logic [`SFRP_LOW_W-1:0]   C_LOW = LW'(`SFRP_CYC(`SFRP_T_LOW_NS));

  if (P_CHIP_CYC >= (1 << RW) || P_WRSTAT_CYC >= (1 << RW) || P_BLOCK_CYC >= (1 << RW) ||
      P_SECTOR_CYC >= (1 << RW) || P_POR_CYC == 0 || P_READ_CYC == 0 ||
      P_DECODE_CYC == 0 || P_PROG_CYC == 0) begin : g_bad_cnt
    $error("sfrp_seq: recovery count out of range");
  end

  function automatic logic [`SFRP_REC_W-1:0] rec_cycles(input sfrp_op_t op);
    unique case (op)
      SFRP_OP_DECODE: rec_cycles = RW'(P_DECODE_CYC);
      SFRP_OP_PROG:   rec_cycles = RW'(P_PROG_CYC);
      SFRP_OP_SECTOR: rec_cycles = RW'(P_SECTOR_CYC);
      SFRP_OP_BLOCK:  rec_cycles = RW'(P_BLOCK_CYC);
      SFRP_OP_CHIP:   rec_cycles = RW'(P_CHIP_CYC);
      SFRP_OP_WRSTAT: rec_cycles = RW'(P_WRSTAT_CYC);
      default:        rec_cycles = RW'(P_READ_CYC);
    endcase
  endfunction : rec_cycles

  function automatic logic is_write_op(input sfrp_op_t op);
    is_write_op = (op == SFRP_OP_PROG) || (op == SFRP_OP_SECTOR) || (op == SFRP_OP_BLOCK) ||
                  (op == SFRP_OP_CHIP) || (op == SFRP_OP_WRSTAT);
  endfunction : is_write_op

  // Pin and supply synchronisers; the pin is asynchronous to the core
  logic pin_s1_q, pin_s2_q, sup_s1_q, sup_s2_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      sup_s1_q <= 1'b1;
      sup_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= i_reset_pin_n;
      pin_s2_q <= pin_s1_q;
      sup_s1_q <= i_supply_low;
      sup_s2_q <= sup_s1_q;
    end
  end

  // Sequencer state
  sfrp_state_t         state_q, state_d;
  logic [LW-1:0]       low_q, low_d;
  logic [RW-1:0]       rec_q, rec_d;
  sfrp_op_t            op_q, op_d;
  sfrp_status_t        stat_d;
  logic                abort_d, clr_d;

  always_comb begin
    state_d = state_q;
    low_d   = low_q;
    rec_d   = rec_q;
    op_d    = op_q;
    abort_d = 1'b0;
    clr_d   = 1'b0;
    if (sup_s2_q) begin
      state_d = SFRP_ST_POR;
      rec_d   = RW'(P_POR_CYC);
    end else begin
      unique case (state_q)
        SFRP_ST_POR: begin
          state_d = SFRP_ST_RECOVER;
          rec_d   = RW'(P_POR_CYC);
          clr_d   = 1'b1;
        end
        SFRP_ST_RUN: begin
          if (!pin_s2_q) begin
            state_d = SFRP_ST_RST_LOW;
            low_d   = LW'(1);
            op_d    = i_op;
          end
        end
        SFRP_ST_RST_LOW: begin
          if (pin_s2_q && low_q == C_LOW) begin
            state_d = SFRP_ST_RECOVER;
            rec_d   = rec_cycles(op_q);
          end else if (pin_s2_q) begin
            // Glitches shorter than the minimum width leave the core alone;
            // run parks the count at one, so more means a recovery was cut
            state_d = (rec_q > RW'(1)) ? SFRP_ST_RECOVER : SFRP_ST_RUN;
          end else if (low_q != C_LOW) begin
            low_d = low_q + LW'(1);
            if (low_d == C_LOW) begin
              clr_d   = 1'b1;
              abort_d = is_write_op(op_q);
            end
          end
        end
        SFRP_ST_RECOVER: begin
          if (!pin_s2_q) begin
            state_d = SFRP_ST_RST_LOW;
            low_d   = LW'(1);
          end else if (rec_q <= RW'(1)) begin
            state_d = SFRP_ST_RUN;
          end else begin
            rec_d = rec_q - RW'(1);
          end
        end
        default: state_d = SFRP_ST_POR;
      endcase
    end
    stat_d.core_rst  = (state_d == SFRP_ST_POR) || (state_d == SFRP_ST_RECOVER) ||
                       (state_d == SFRP_ST_RST_LOW && low_d == C_LOW);
    stat_d.so_hiz    = (state_d != SFRP_ST_RUN) || !pin_s2_q;
    stat_d.cmd_ready = (state_d == SFRP_ST_RUN);
    stat_d.standby   = (state_d == SFRP_ST_RUN) || (state_d == SFRP_ST_RECOVER);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q                  <= SFRP_ST_POR;
      low_q                    <= '0;
      rec_q                    <= '0;
      op_q                     <= SFRP_OP_IDLE;
      o_status                 <= '{core_rst: 1'b1, so_hiz: 1'b1, cmd_ready: 1'b0, standby: 1'b0};
      o_abort                  <= 1'b0;
      o_clear_volatile         <= 1'b0;
      o_write_enable_latch_clr <= 1'b0;
    end else begin
      state_q                  <= state_d;
      low_q                    <= low_d;
      rec_q                    <= rec_d;
      op_q                     <= op_d;
      o_status                 <= stat_d;
      o_abort                  <= abort_d;
      o_clear_volatile         <= clr_d;
      o_write_enable_latch_clr <= clr_d;
    end
  end

  // Parameter table and read framing
  logic [7:0] pbyte_d;
  logic [6:0] lead_d;

  always_comb begin
    o_sfdp_legal = (i_sfdp_lanes.op_lanes == i_sfdp_lanes.addr_lanes) &&
                   (i_sfdp_lanes.op_lanes == i_sfdp_lanes.data_lanes) &&
                   (i_sfdp_lanes.op_lanes == 3'h1 || i_sfdp_lanes.op_lanes == 3'h2 ||
                    i_sfdp_lanes.op_lanes == 3'h4);
    unique case (i_param_addr)
      `SFRP_OFS_ERASE_4K:  pbyte_d = `SFRP_EXP_4K;
      `SFRP_OFS_ERASE_32K: pbyte_d = `SFRP_EXP_32K;
      `SFRP_OFS_ERASE_64K: pbyte_d = `SFRP_EXP_64K;
      default:             pbyte_d = `SFRP_BLANK;
    endcase
    // Mode bits sit right after the address, wait states after both
    lead_d = 7'(i_addr_bits) + 7'(i_mode_bits) + 7'(i_wait_states);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_param_byte <= `SFRP_BLANK;
      o_data_lead  <= '0;
    end else begin
      o_param_byte <= pbyte_d;
      o_data_lead  <= lead_d;
    end
  end

  // Checks
  chk_short_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RST_LOW && low_q != C_LOW && pin_s2_q && !sup_s2_q && rec_q <= RW'(1)
      |=> state_q == SFRP_ST_RUN && !o_clear_volatile)
    else $error("short reset pulse not ignored");
  chk_glitch_resume: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RST_LOW && low_q != C_LOW && pin_s2_q && !sup_s2_q && rec_q > RW'(1)
      |=> state_q == SFRP_ST_RECOVER && !o_status.cmd_ready && !o_clear_volatile)
    else $error("glitch cut recovery short");
  chk_full_reset: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RST_LOW && low_q == C_LOW - LW'(1) && !pin_s2_q && !sup_s2_q
      |=> o_clear_volatile && o_status.core_rst && o_write_enable_latch_clr)
    else $error("full reset did not clear volatile state");
  chk_abort_cause: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_abort |-> is_write_op(op_q) && $past(state_q) == SFRP_ST_RST_LOW && low_q == C_LOW)
    else $error("abort without program or erase");
  chk_so_hiz: assert property (@(posedge i_mclk) disable iff (i_rst)
    !pin_s2_q |=> o_status.so_hiz)
    else $error("output driven during reset");
  chk_por_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    sup_s2_q |=> state_q == SFRP_ST_POR && o_status.core_rst && !o_status.cmd_ready)
    else $error("logic not held during low supply");
  chk_rec_load: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RST_LOW && low_q == C_LOW && pin_s2_q && !sup_s2_q
      |=> state_q == SFRP_ST_RECOVER && rec_q == rec_cycles(op_q))
    else $error("wrong recovery count loaded");
  chk_rec_end: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RECOVER && rec_q > RW'(1) |=> !o_status.cmd_ready)
    else $error("commands accepted before recovery");
  chk_rec_done: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RECOVER && rec_q == RW'(1) && pin_s2_q && !sup_s2_q
      |=> o_status.cmd_ready && !o_status.so_hiz)
    else $error("recovery did not end");
  chk_sfdp_modes: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_sfdp_legal |-> i_sfdp_lanes.data_lanes inside {3'h1, 3'h2, 3'h4})
    else $error("illegal lane form accepted");
  chk_erase_exp: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_param_addr == `SFRP_OFS_ERASE_32K |=> o_param_byte == `SFRP_EXP_32K)
    else $error("wrong erase exponent");
  chk_blank_fill: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(i_param_addr inside {`SFRP_OFS_ERASE_4K, `SFRP_OFS_ERASE_32K, `SFRP_OFS_ERASE_64K})
      |=> o_param_byte == `SFRP_BLANK)
    else $error("unused location not blank");
  chk_data_lead: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_data_lead == 7'($past(i_addr_bits)) + 7'($past(i_mode_bits)) +
                       7'($past(i_wait_states)))
    else $error("data lead mismatch");

  cov_prog_abort: cover property (@(posedge i_mclk) disable iff (i_rst) o_abort);
  cov_glitch: cover property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RST_LOW ##1 state_q == SFRP_ST_RUN);
  cov_por_done: cover property (@(posedge i_mclk) disable iff (i_rst)
    state_q == SFRP_ST_RECOVER ##1 state_q == SFRP_ST_RUN);

endmodule : sfrp_seq

// [sfrp_host.sv]
// Host-side model: reset pin, supply monitor and running operation
`timescale 1ns/1ps
module sfrp_host
  import sfrp_pkg::*;
(
  // Clock
  input  wire logic i_mclk,
  // Device side
  output logic      o_reset_pin_n,
  output logic      o_supply_low,
  output sfrp_op_t  o_op
);
  initial begin
    o_reset_pin_n = 1'b1;
    o_supply_low  = 1'b0;
    o_op          = SFRP_OP_IDLE;
  end
  // Changes only at falling edge, away from the sampling edge
  task automatic set_pin(input logic v);
    @(negedge i_mclk);
    o_reset_pin_n = v;
  endtask : set_pin
  // Supply stays low as long as the caller says
  task automatic set_supply(input logic v);
    @(negedge i_mclk);
    o_supply_low = v;
  endtask : set_supply
  task automatic set_op(input sfrp_op_t v);
    @(negedge i_mclk);
    o_op = v;
  endtask : set_op
endmodule : sfrp_host

// [test_serial_flash_reset_power_on.sv]
// Self-checking bench for the reset and power-on sequencer
`timescale 1ns/1ps
module test_serial_flash_reset_power_on
  import sfrp_pkg::*;
;
  localparam int POR = 7000;
  localparam int LOW = 2000;
  // Recovery per latched op; idle uses the read figure, long ones shortened
  int           rec_tbl [8] = '{7000, 8000, 7000, 50, 60, 70, 80, 90};
  int           tbl [int];
  logic         i_mclk = 1'b0;
  logic         i_rst;
  logic         pin_n, sup_low;
  sfrp_op_t     op;
  sfrp_status_t o_status;
  logic         o_abort, o_clr, o_wel;
  sfrp_lanes_t  i_sfdp_lanes;
  logic         o_sfdp_legal;
  logic [8:0]   i_param_addr;
  logic [7:0]   o_param_byte;
  logic [5:0]   i_addr_bits;
  logic [3:0]   i_mode_bits;
  logic [4:0]   i_wait_states;
  logic [6:0]   o_data_lead;
  int           miscompares = 0;
  int           cmp_count = 0;
  int           n_clr = 0, n_abort = 0, n_wel = 0;
  int           c0, a0, w0, e, x;

  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (o_clr === 1'b1) n_clr++;
    if (o_abort === 1'b1) n_abort++;
    if (o_wel === 1'b1) n_wel++;
  end

  sfrp_host host (.i_mclk(i_mclk), .o_reset_pin_n(pin_n), .o_supply_low(sup_low), .o_op(op));
  sfrp_seq #(.P_PROG_CYC(50), .P_SECTOR_CYC(60), .P_BLOCK_CYC(70), .P_CHIP_CYC(80),
    .P_WRSTAT_CYC(90)) DUT (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_pin_n(pin_n), .i_supply_low(sup_low),
    .i_op(op), .o_status(o_status), .o_abort(o_abort), .o_clear_volatile(o_clr),
    .o_write_enable_latch_clr(o_wel), .i_sfdp_lanes(i_sfdp_lanes),
    .o_sfdp_legal(o_sfdp_legal), .i_param_addr(i_param_addr), .o_param_byte(o_param_byte),
    .i_addr_bits(i_addr_bits), .i_mode_bits(i_mode_bits), .i_wait_states(i_wait_states),
    .o_data_lead(o_data_lead));

  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : chk
  // Counts cycles to command readiness; must not come early or late
  task automatic wait_ready(input int rec);
    int n;
    n = 0;
    while (o_status.cmd_ready !== 1'b1) begin
      @(negedge i_mclk);
      n++;
      if (n > rec + 50) begin
        miscompares++;
        $display("FAIL cmd_ready expected within %0d seen none", rec + 8);
        conclude();
      end
    end
    cmp_count++;
    if (n < rec || n > rec + 8) begin
      miscompares++;
      $display("FAIL recovery expected %0d seen %0d", rec, n);
    end
  endtask : wait_ready

  initial begin
    x = $urandom(32'hefb474e9);
    i_rst = 1'b1;
    i_sfdp_lanes = '0;
    i_param_addr = '0;
    i_addr_bits = '0;
    i_mode_bits = '0;
    i_wait_states = '0;
    tbl[9'h01c] = 8'h0c;
    tbl[9'h01e] = 8'h0f;
    tbl[9'h020] = 8'h10;
    repeat (5) @(negedge i_mclk);
    chk("core_rst", 1, o_status.core_rst);
    chk("so_hiz", 1, o_status.so_hiz);
    i_rst = 1'b0;
    wait_ready(POR);
    chk("standby", 1, o_status.standby);
    for (int k = 0; k < 8; k++) begin
      host.set_op(sfrp_op_t'(k));
      c0 = n_clr;
      a0 = n_abort;
      w0 = n_wel;
      host.set_pin(1'b0);
      repeat (5) @(negedge i_mclk);
      chk("so_hiz_low", 1, o_status.so_hiz);
      chk("cmd_ready_low", 0, o_status.cmd_ready);
      repeat (LOW + 10) @(negedge i_mclk);
      chk("core_rst_low", 1, o_status.core_rst);
      host.set_pin(1'b1);
      chk("clear", c0 + 1, n_clr);
      chk("wel_clr", w0 + 1, n_wel);
      chk("abort", a0 + (k >= 3), n_abort);
      wait_ready(rec_tbl[k]);
      chk("so_out", 0, o_status.so_hiz);
      chk("standby_after", 1, o_status.standby);
    end
    // Short pulse: refused as a reset, output still floated
    c0 = n_clr;
    host.set_pin(1'b0);
    repeat (LOW - 10) @(negedge i_mclk);
    chk("so_hiz_short", 1, o_status.so_hiz);
    host.set_pin(1'b1);
    wait_ready(0);
    chk("clear_short", c0, n_clr);
    // Glitch inside a recovery only pauses the count
    host.set_op(SFRP_OP_CHIP);
    host.set_pin(1'b0);
    repeat (LOW + 10) @(negedge i_mclk);
    host.set_pin(1'b1);
    repeat (20) @(negedge i_mclk);
    host.set_pin(1'b0);
    repeat (4) @(negedge i_mclk);
    chk("ready_glitch", 0, o_status.cmd_ready);
    host.set_pin(1'b1);
    wait_ready(rec_tbl[6] - 20);
    host.set_supply(1'b1);
    repeat (6) @(negedge i_mclk);
    chk("por_core", 1, o_status.core_rst);
    chk("por_ready", 0, o_status.cmd_ready);
    c0 = n_clr;
    host.set_supply(1'b0);
    wait_ready(POR);
    chk("por_clear", c0 + 1, n_clr);
    for (int i = 0; i < 40; i++) begin
      i_param_addr = (i < 3) ? 9'(9'h01c + 2 * i) : 9'($urandom % 512);
      e = tbl.exists(int'(i_param_addr)) ? tbl[int'(i_param_addr)] : 8'hff;
      @(negedge i_mclk);
      chk("param_byte", e, o_param_byte);
      i_sfdp_lanes = '{3'(1 << ($urandom % 4)), 3'(1 << ($urandom % 4)), 3'($urandom)};
      if (i % 2 == 0) i_sfdp_lanes.data_lanes = i_sfdp_lanes.op_lanes;
      if (i % 4 == 0) i_sfdp_lanes.addr_lanes = i_sfdp_lanes.op_lanes;
      i_addr_bits = 6'($urandom);
      i_mode_bits = 4'($urandom);
      i_wait_states = 5'($urandom);
      e = (i_sfdp_lanes.op_lanes == i_sfdp_lanes.addr_lanes)
        && (i_sfdp_lanes.op_lanes == i_sfdp_lanes.data_lanes)
        && (i_sfdp_lanes.op_lanes inside {3'd1, 3'd2, 3'd4});
      #1 chk("sfdp_legal", e, o_sfdp_legal);
      e = i_addr_bits + i_mode_bits + i_wait_states;
      @(negedge i_mclk);
      chk("data_lead", e, o_data_lead);
    end
    conclude();
  end
endmodule : test_serial_flash_reset_power_on
